/* File: src/intc_latch_enable.sv */
// pending latches, enable register and acceptance handshake
`timescale 1ns/1ps
module intc_latch_enable #(
    parameter int ACCEPT_LEN = intc_pkg::ACCEPT_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic [15:0] i_source_req,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    input wire logic i_instr_end,
    input wire logic i_unmask_all_instr,
    input wire logic i_mask_all_instr,
    input wire logic i_return_instr,
    input wire logic i_stacked_master,
    output logic o_irq_pending,
    output logic [3:0] o_irq_index,
    output logic o_accept_busy,
    output logic o_accept_done,
    output logic o_master_to_stack,
    output logic o_master_enable_flag
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACCEPT = 2'b01
    } accept_e;

    initial begin
        if (ACCEPT_LEN < 1 || ACCEPT_LEN > 255) begin
            $error("acceptance length out of range");
        end
    end

    logic [15:0] src_s1_reg;
    logic [15:0] src_s2_reg;
    logic [15:0] src_s3_reg;
    logic [15:0] src_agree;
    logic [15:0] pending_latch_reg;
    logic [15:0] pending_latch_next;
    logic [15:0] enable_reg;
    logic master_enable_flag_reg;
    accept_e state_reg;
    logic [7:0] count_reg;
    logic [3:0] accepted_reg;
    logic [15:0] eligible;
    logic pick_any;
    logic [3:0] pick_index;
    logic [15:0] accept_clear;
    logic [15:0] sw_clear;

    // the master flag has its own register; its byte position stays zero here
    // so a mask or an acceptance is never hidden by a stale written bit on read
    localparam logic [7:0] MASTER_BYTE_BIT = 8'(1 << intc_pkg::MASTER_BIT);

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction

    // three-stage synchroniser; a rising change counts once stages two and three agree
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            src_s1_reg <= 16'h0000;
            src_s2_reg <= 16'h0000;
            src_s3_reg <= 16'h0000;
        end else begin
            src_s1_reg <= i_source_req;
            src_s2_reg <= src_s1_reg;
            src_s3_reg <= src_s2_reg;
        end
    end

    assign src_agree = ~(src_s2_reg ^ src_s3_reg);

    // filtered level follows the third stage only while the second agrees,
    // so a one-cycle glitch on a request pin never sets a latch
    logic [15:0] src_prev_reg;
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            src_prev_reg <= 16'h0000;
        end else begin
            src_prev_reg <= (src_prev_reg & ~src_agree) | (src_s3_reg & src_agree);
        end
    end

    logic [15:0] req_event;
    assign req_event = src_agree & src_s3_reg & ~src_prev_reg & intc_pkg::LATCH_MASK;

    // eligibility: non-maskable ignore enables, maskable need master and own flag
    assign eligible = pending_latch_reg & (intc_pkg::NMI_MASK
        | ({16{master_enable_flag_reg}} & enable_reg & intc_pkg::LATCH_MASK
           & ~intc_pkg::NMI_MASK));

    intc_priority #(
        .WIDTH(intc_pkg::NUM_SOURCES)
    ) u_pick (
        .i_req(eligible),
        .o_any(pick_any),
        .o_index(pick_index)
    );

    logic start_accept;
    assign start_accept = (state_reg == ST_IDLE) && i_instr_end && pick_any;

    always_comb begin
        accept_clear = 16'h0000;
        if (start_accept) begin
            accept_clear[pick_index] = 1'b1;
        end
    end

    always_comb begin
        sw_clear = 16'h0000;
        if (i_sfr_wr && hit(i_sfr_addr, intc_pkg::ADDR_PENDING_LOW)) begin
            sw_clear[7:0] = ~i_sfr_wdata;
        end
        if (i_sfr_wr && hit(i_sfr_addr, intc_pkg::ADDR_PENDING_HIGH)) begin
            sw_clear[15:8] = ~i_sfr_wdata;
        end
    end

    // writes only clear; a simultaneous request wins over any clear
    assign pending_latch_next = ((pending_latch_reg & ~sw_clear & ~accept_clear) | req_event)
        & intc_pkg::LATCH_MASK;

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            pending_latch_reg <= 16'h0000;
        end else begin
            pending_latch_reg <= pending_latch_next;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            enable_reg <= 16'h0000;
        end else begin
            if (i_sfr_wr && hit(i_sfr_addr, intc_pkg::ADDR_ENABLE_LOW)) begin
                enable_reg[7:0] <= i_sfr_wdata & intc_pkg::ENABLE_MASK[7:0]
                    & ~MASTER_BYTE_BIT;
            end
            if (i_sfr_wr && hit(i_sfr_addr, intc_pkg::ADDR_ENABLE_HIGH)) begin
                enable_reg[15:8] <= i_sfr_wdata;
            end
        end
    end

    // master flag: acceptance outranks other sources, then return, instructions, writes
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            master_enable_flag_reg <= 1'b0;
        end else if (start_accept) begin
            master_enable_flag_reg <= 1'b0;
        end else if (i_return_instr) begin
            master_enable_flag_reg <= i_stacked_master;
        end else if (i_unmask_all_instr) begin
            master_enable_flag_reg <= 1'b1;
        end else if (i_mask_all_instr) begin
            master_enable_flag_reg <= 1'b0;
        end else if (i_sfr_wr && hit(i_sfr_addr, intc_pkg::ADDR_ENABLE_LOW)) begin
            master_enable_flag_reg <= i_sfr_wdata[intc_pkg::MASTER_BIT];
        end
    end

    // stacked copy is taken before the flag clears
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_master_to_stack <= 1'b0;
        end else if (start_accept) begin
            o_master_to_stack <= master_enable_flag_reg;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= ST_IDLE;
            count_reg <= 8'h00;
            accepted_reg <= 4'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_accept) begin
                        state_reg <= ST_ACCEPT;
                        count_reg <= 8'(ACCEPT_LEN - 1);
                        accepted_reg <= pick_index;
                    end
                end
                ST_ACCEPT: begin
                    if (count_reg == 8'h00) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        count_reg <= count_reg - 8'h01;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_accept_busy <= 1'b0;
            o_accept_done <= 1'b0;
            o_irq_index <= 4'h0;
            o_irq_pending <= 1'b0;
            o_master_enable_flag <= 1'b0;
        end else begin
            o_accept_busy <= start_accept
                || (state_reg == ST_ACCEPT && count_reg != 8'h00);
            o_accept_done <= (state_reg == ST_ACCEPT) && (count_reg == 8'h00);
            o_irq_index <= start_accept ? pick_index : accepted_reg;
            o_irq_pending <= pick_any && !start_accept;
            o_master_enable_flag <= master_enable_flag_reg;
        end
    end

    // read data registered one cycle after the strobe
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_sfr_rdata <= 8'h00;
        end else if (i_sfr_rd) begin
            case (i_sfr_addr)
                intc_pkg::ADDR_ENABLE_LOW: o_sfr_rdata <= enable_reg[7:0]
                    | {7'h00, master_enable_flag_reg};
                intc_pkg::ADDR_ENABLE_HIGH: o_sfr_rdata <= enable_reg[15:8];
                intc_pkg::ADDR_PENDING_LOW: o_sfr_rdata <= pending_latch_reg[7:0];
                intc_pkg::ADDR_PENDING_HIGH: o_sfr_rdata <= pending_latch_reg[15:8];
                default: o_sfr_rdata <= 8'h00;
            endcase
        end
    end

    pick_lowest_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        start_accept |-> (eligible & ((16'h0001 << pick_index) - 16'h0001)) == 16'h0000)
        else $error("lower eligible source passed over");

    latch_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        start_accept && !req_event[pick_index] |=> !pending_latch_reg[$past(pick_index)])
        else $error("accepted latch not cleared");
    sw_no_set_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (req_event == 16'h0000) |=> (pending_latch_reg & ~$past(pending_latch_reg)) == 16'h0000)
        else $error("latch set without request");
    req_wins_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        req_event != 16'h0000 |=> (pending_latch_reg & $past(req_event)) == $past(req_event))
        else $error("request lost");
    master_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        start_accept && !master_enable_flag_reg |-> pick_index inside {4'h2, 4'h3})
        else $error("maskable accepted while masked");
    master_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        start_accept |=> !master_enable_flag_reg && o_master_to_stack == $past(master_enable_flag_reg))
        else $error("master not stacked and cleared");
    master_return_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        !start_accept && i_return_instr |=> master_enable_flag_reg == $past(i_stacked_master))
        else $error("return did not reload master");
    nmi_free_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        state_reg == ST_IDLE && i_instr_end && pending_latch_reg[2] |-> start_accept)
        else $error("non-maskable not taken");
    accept_len_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        start_accept |-> ##9 o_accept_done)
        else $error("acceptance end misplaced");
    busy_len_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        start_accept |=> o_accept_busy [*8] ##1 !o_accept_busy)
        else $error("busy not eight cycles");
    enable_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        start_accept && pick_index >= 4'h4 |-> enable_reg[pick_index])
        else $error("disabled source accepted");
endmodule

/* File: include/intc_pkg.sv */
// constants for the interrupt latch and enable unit
package intc_pkg;
    localparam logic [7:0] ADDR_ENABLE_LOW = 8'h3a;
    localparam logic [7:0] ADDR_ENABLE_HIGH = 8'h3b;
    localparam logic [7:0] ADDR_PENDING_LOW = 8'h3c;
    localparam logic [7:0] ADDR_PENDING_HIGH = 8'h3d;
    localparam int NUM_SOURCES = 16;
    localparam int FIRST_LATCH = 2;
    localparam int FIRST_MASKABLE = 4;
    localparam int MASTER_BIT = 0;
    localparam logic [15:0] LATCH_MASK = 16'hfffc;
    localparam logic [15:0] ENABLE_MASK = 16'hfff1;
    localparam logic [15:0] NMI_MASK = 16'h000c;
    localparam int ACCEPT_CYCLES = 8;
endpackage

/* File: src/intc_priority.sv */
// fixed priority picker: lowest set index wins
`timescale 1ns/1ps
module intc_priority #(
    parameter int WIDTH = 16
) (
    input wire logic [WIDTH-1:0] i_req,
    output logic o_any,
    output logic [3:0] o_index
);
    initial begin
        if (WIDTH > 16) begin
            $error("priority picker width above 16 not supported");
        end
    end

    always_comb begin
        o_any = 1'b0;
        o_index = 4'h0;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (i_req[i]) begin
                o_any = 1'b1;
                o_index = 4'(i);
            end
        end
    end
endmodule

/* File: test/core_model.sv */
// behavioural cpu core: ends instructions on request and keeps the stacked master enable
`timescale 1ns/1ps
module core_model #(
    parameter int GAP = 3
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_go,
    input wire logic i_ret,
    input wire logic i_busy,
    input wire logic i_master_saved,
    output logic o_instr_end,
    output logic o_return_instr,
    output logic o_stacked_master
);
    int cnt;
    logic busy_reg;
    // a gap between instruction ends exercises both prompt and slow acceptance starts
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt <= 0;
            o_instr_end <= 1'b0;
            o_return_instr <= 1'b0;
            busy_reg <= 1'b0;
            o_stacked_master <= 1'b0;
        end else begin
            cnt <= (cnt == 0) ? GAP : cnt - 1;
            o_instr_end <= i_go && (cnt == 0);
            o_return_instr <= i_ret;
            busy_reg <= i_busy;
            if (i_busy && !busy_reg) begin
                o_stacked_master <= i_master_saved;
            end
        end
    end
endmodule

/* File: test/testbench.sv */
// self-checking bench for the interrupt latch and enable unit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module testbench;
    logic clk = 0, rst = 1, wr = 0, rd = 0, unmask = 0, mask = 0, go = 0, ret = 0;
    logic [15:0] src = '0, v, e, s;
    logic [7:0] addr = '0, wdata = '0, rdata;
    logic instr_end, ret_instr, stacked, pend, busy, done, to_stack, master;
    logic [3:0] idx;
    int fail_count = 0, n_compared = 0;
    intc_latch_enable #(.ACCEPT_LEN(8)) dut_u (.i_ref_clk(clk), .i_reset(rst),
        .i_source_req(src), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd),
        .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_instr_end(instr_end),
        .i_unmask_all_instr(unmask), .i_mask_all_instr(mask), .i_return_instr(ret_instr),
        .i_stacked_master(stacked), .o_irq_pending(pend), .o_irq_index(idx),
        .o_accept_busy(busy), .o_accept_done(done), .o_master_to_stack(to_stack),
        .o_master_enable_flag(master));
    core_model core_u (.i_ref_clk(clk), .i_reset(rst), .i_go(go), .i_ret(ret),
        .i_busy(busy), .i_master_saved(to_stack), .o_instr_end(instr_end),
        .o_return_instr(ret_instr), .o_stacked_master(stacked));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk); addr = a; wdata = d; wr = 1;
        @(negedge clk); wr = 0;
    endtask
    // low byte then high byte as two back-to-back reads
    task automatic rd16(input logic [7:0] a, output logic [15:0] r);
        @(negedge clk); addr = a; rd = 1;
        @(negedge clk); addr = a + 8'h01; r[7:0] = rdata;
        @(negedge clk); rd = 0; r[15:8] = rdata;
    endtask
    task automatic instr(input int k);
        @(negedge clk); unmask = (k == 0); mask = (k == 1); ret = (k == 2);
        @(negedge clk); unmask = 0; mask = 0; ret = 0;
        repeat (4) @(negedge clk);
    endtask
    task automatic raise(input logic [15:0] m);
        @(negedge clk); src = m;
        repeat (6) @(negedge clk);
        src = '0;
        repeat (6) @(negedge clk);
    endtask
    task automatic accept(input logic [3:0] ei, input logic es);
        int n = 0;
        @(negedge clk); go = 1;
        while (busy !== 1'b1 && n < 40) begin @(negedge clk); n++; end
        go = 0;
        `CHK("accept start", 1'b1, busy)
        `CHK("index", ei, idx)
        `CHK("master stacked", es, to_stack)
        n = 0;
        while (busy === 1'b1 && n < 20) begin @(negedge clk); n++; end
        `CHK("busy length", 8, n)
        `CHK("done pulse", 1'b1, done)
        `CHK("master cleared", 1'b0, master)
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        print_verdict;
    end
    initial begin
        void'($urandom(87));
        repeat (8) @(negedge clk);
        rst = 0;
        rd16(8'h3a, v); `CHK("enable reset", 16'h0000, v)
        rd16(8'h3c, v); `CHK("latch reset", 16'h0000, v)
        wr8(8'h40, 8'hff);
        rd16(8'h40, v); `CHK("unmapped", 16'h0000, v)
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            e = 16'($urandom) & 16'hfffe;
            wr8(8'h3a, e[7:0]);
            wr8(8'h3b, e[15:8]);
            rd16(8'h3a, v); `CHK("enable rw", e & intc_pkg::ENABLE_MASK, v)
        end
        wr8(8'h3a, 8'h00);
        wr8(8'h3b, 8'h00);
        wr8(8'h3a, 8'h01);
        rd16(8'h3a, v); `CHK("master write", 16'h0001, v)
        instr(1);
        rd16(8'h3a, v); `CHK("master masked", 16'h0000, v)
        $display("test enable done");
        s = 16'($urandom) & 16'hfff3;
        raise(s);
        rd16(8'h3c, v); `CHK("latch set", s & intc_pkg::LATCH_MASK, v)
        `CHK("pending masked", 1'b0, pend)
        wr8(8'h3c, 8'hff);
        wr8(8'h3d, 8'hff);
        rd16(8'h3c, v); `CHK("latch kept", s & intc_pkg::LATCH_MASK, v)
        e = 16'($urandom) | 16'h000c;
        wr8(8'h3c, e[7:0]);
        wr8(8'h3d, e[15:8]);
        rd16(8'h3c, v); `CHK("latch clear", s & e & intc_pkg::LATCH_MASK, v)
        wr8(8'h3c, 8'h0c);
        wr8(8'h3d, 8'h00);
        rd16(8'h3c, v); `CHK("latch empty", 16'h0000, v)
        $display("test latch done");
        // enables changed while the master enable is still off
        raise(16'h0220);
        wr8(8'h3a, 8'h20);
        wr8(8'h3b, 8'h02);
        `CHK("master off", 1'b0, pend)
        instr(0); `CHK("unmask", 1'b1, master)
        `CHK("pending offered", 1'b1, pend)
        accept(4'h5, 1'b1);
        rd16(8'h3c, v); `CHK("accepted cleared", 16'h0200, v)
        instr(2); `CHK("return restores", 1'b1, master)
        accept(4'h9, 1'b1);
        wr8(8'h3b, 8'h00);
        instr(0); `CHK("nested unmask", 1'b1, master)
        `CHK("nothing left", 1'b0, pend)
        instr(1); `CHK("mask", 1'b0, master)
        rd16(8'h3a, v); `CHK("master bit", 16'h0020, v)
        $display("test accept done");
        wr8(8'h3a, 8'h00);
        wr8(8'h3b, 8'h00);
        instr(0);
        raise(16'h000c);
        accept(4'h2, 1'b1);
        instr(2); `CHK("return nonmask", 1'b1, master)
        accept(4'h3, 1'b1);
        instr(2); `CHK("return again", 1'b1, master)
        rd16(8'h3c, v); `CHK("nmi latches cleared", 16'h0000, v)
        $display("test nonmaskable done");
        print_verdict;
    end
endmodule
